// ===== i2c_seq_pkg.sv
package i2c_seq_pkg;
  localparam int         DIV_W          = 7;      // divider width, bits 6:0
  localparam logic [6:0] DIV_RESET      = 7'h09;  // default divider after reset
  localparam logic [6:0] CNT_ONE        = 7'h01;
  localparam logic [6:0] CNT_ZERO       = 7'h00;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam int         BIT_ACK_EN     = 4;      // control bit of the ack sequence enable
  localparam int         BIT_STOP_EN    = 2;      // control bit of the stop sequence enable
  localparam int         BIT_STOP_SEEN  = 4;      // status bit of the stop-detected flag

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00000,
    ST_ST_HI   = 5'b00001,  // start: both high, counting
    ST_ST_SDA  = 5'b00010,  // start: sda low, counting
    ST_RS_SCLL = 5'b00011,  // repeated start: scl low, sda released
    ST_RS_SCLH = 5'b00100,  // repeated start: scl released, waiting high
    ST_RS_HI   = 5'b00101,  // repeated start: both high, counting
    ST_RS_SDA  = 5'b00110,  // repeated start: sda low, counting
    ST_TX_LO   = 5'b00111,  // bit time, scl low
    ST_TX_HI   = 5'b01000,  // bit time, scl high
    ST_TX_WAIT = 5'b01001,  // waiting scl high (stretch)
    ST_AK_LO   = 5'b01010,
    ST_AK_WAIT = 5'b01011,
    ST_AK_HI   = 5'b01100,
    ST_SP_LO   = 5'b01101,  // stop: sda driven low, waiting sample
    ST_SP_CNT  = 5'b01110,
    ST_SP_SCL  = 5'b01111,  // stop: scl released, one period
    ST_SP_DET  = 5'b10000,  // stop: sda released, wait for stop
    ST_SP_END  = 5'b10001   // stop: one period before finish
  } seq_state_e;
endpackage

// ===== i2c_host_seq.sv
// Behaviour
// - ack enable: hold scl low, drive ack value
// - ack: one period, release scl, period, low
// - ack end: clear enable, stop generator, idle
// - buffer write during ack/stop: collision flag
// - stop: sda low, count, release scl, sda
// - stop seen sets flag; period later irq
// - sleep: keep receiving, wake if enabled
// - reset/disable aborts, clears start/stop flags
// - busy bus: stop raises interrupt if enabled
// - released sda read low: collision, idle
// - tx collision: halt, clear full, release
// - sequence collision: abort, release, clear enable
// - after collision watch bus, stop sets irq
// - new write restarts byte at first bit
// - start with line low: collision, idle
// - start: load divider, scl low is collision
// - start: early sda on fall, then scl low
// - rstart: count, release scl, check sda
// - rstart: scl fall before sda low collides
// - rstart: both high, sda low, scl low
`timescale 1ns/100ps
module i2c_host_seq #(
  parameter int DIV_W = i2c_seq_pkg::DIV_W
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             module_enable,
  input  wire logic [DIV_W-1:0] baud_divider_reg,
  input  wire logic             irq_enable,
  input  wire logic             sleep_mode,
  input  wire logic             start_req,
  input  wire logic             rstart_req,
  input  wire logic             ack_req,
  input  wire logic             stop_req,
  input  wire logic             ack_data_value,
  input  wire logic             buf_write,
  input  wire logic [7:0]       buf_wdata,
  input  wire logic             write_collision_flag_clear,
  input  wire logic             bcol_clear,
  input  wire logic             irq_clear,
  input  wire logic             sda_in,
  input  wire logic             scl_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  output logic                  scl_out,
  output logic                  scl_oe,
  output logic                  ack_seq_enable,
  output logic                  stop_seq_enable,
  output logic                  start_seq_enable,
  output logic                  rstart_seq_enable,
  output logic [7:0]            transfer_buffer,
  output logic                  buffer_full_flag,
  output logic                  write_collision_flag,
  output logic                  bus_collision_flag,
  output logic                  serial_irq_flag,
  output logic                  start_seen,
  output logic                  stop_seen,
  output logic                  wake_req
);
  // counter and reload port share this width; the divider field has no more than seven bits
  if (DIV_W < 2 || DIV_W > 7) begin : g_bad_width
    $error("divider width must be 2..7");
  end

  i2c_seq_pkg::seq_state_e st_q, st_d;
  logic [DIV_W-1:0] cnt_q;
  logic [2:0]       bit_q;
  logic [7:0]       shreg_q;
  logic             sda_drv_q, scl_drv_q;
  logic             sda_p_q, scl_p_q;
  logic             ack_en_q, stop_en_q, st_en_q, rs_en_q;

  // true while a state code lies inside one sequence's block of codes
  function automatic logic st_between(i2c_seq_pkg::seq_state_e s,
                                      i2c_seq_pkg::seq_state_e lo,
                                      i2c_seq_pkg::seq_state_e hi);
    return (s >= lo) && (s <= hi);
  endfunction

  // generator reload value and decodes
  wire [DIV_W-1:0] reload   = baud_divider_reg;
  wire             tout     = (cnt_q == DIV_W'(i2c_seq_pkg::CNT_ZERO));
  wire             in_idle  = (st_q == i2c_seq_pkg::ST_IDLE);
  wire             in_tx    = (st_q == i2c_seq_pkg::ST_TX_LO) || (st_q == i2c_seq_pkg::ST_TX_HI)
                              || (st_q == i2c_seq_pkg::ST_TX_WAIT);
  wire             in_ack   = (st_q == i2c_seq_pkg::ST_AK_LO) || (st_q == i2c_seq_pkg::ST_AK_WAIT)
                              || (st_q == i2c_seq_pkg::ST_AK_HI);
  wire             in_stop  = (st_q >= i2c_seq_pkg::ST_SP_LO);
  wire             busy     = !in_idle;
  wire             cur_bit  = shreg_q[7];
  // bus conditions seen on sampled lines
  wire             start_ev = scl_in && scl_p_q && sda_p_q && !sda_in;
  wire             stop_ev  = scl_in && scl_p_q && !sda_p_q && sda_in;
  // released sda read low while scl high: lost arbitration
  wire             arb_lost = !sda_drv_q && !sda_in && scl_in
                              && (st_q == i2c_seq_pkg::ST_TX_HI || st_q == i2c_seq_pkg::ST_AK_HI);
  // start refused when either line is already low
  wire             st_bad   = in_idle && start_req && (!sda_in || !scl_in);
  // scl low with sda high during first start count
  wire             st_col   = (st_q == i2c_seq_pkg::ST_ST_HI) && !scl_in && sda_in;
  // repeated start collisions
  wire             rs_col   = (st_q == i2c_seq_pkg::ST_RS_SCLH && scl_in && !sda_in)
                              || (st_q == i2c_seq_pkg::ST_RS_HI && !scl_in && sda_in);
  // any collision wins over the state moves below and frees both lines at once
  wire             bcol_ev  = module_enable && (arb_lost || st_bad || st_col || rs_col);
  wire             wr_ok    = buf_write && !busy && module_enable;
  wire             wr_col   = buf_write && (in_ack || in_stop || (busy && !wr_ok));
  wire             stop_fin = (st_q == i2c_seq_pkg::ST_SP_END) && tout;
  wire             byte_end = (st_q == i2c_seq_pkg::ST_TX_HI) && tout && (bit_q == i2c_seq_pkg::BIT_LAST);

  // next state of the sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      i2c_seq_pkg::ST_IDLE: begin
        if (start_req && sda_in && scl_in) st_d = i2c_seq_pkg::ST_ST_HI;
        else if (rstart_req) st_d = i2c_seq_pkg::ST_RS_SCLL;
        else if (ack_req) st_d = i2c_seq_pkg::ST_AK_LO;
        else if (stop_req) st_d = i2c_seq_pkg::ST_SP_LO;
        else if (wr_ok) st_d = i2c_seq_pkg::ST_TX_LO;
      end
      i2c_seq_pkg::ST_ST_HI: if (tout || !sda_in) st_d = i2c_seq_pkg::ST_ST_SDA;
      i2c_seq_pkg::ST_ST_SDA: if (tout) st_d = i2c_seq_pkg::ST_IDLE; // scl low ignored
      i2c_seq_pkg::ST_RS_SCLL: if (tout && sda_in) st_d = i2c_seq_pkg::ST_RS_SCLH;
      i2c_seq_pkg::ST_RS_SCLH: if (scl_in && sda_in) st_d = i2c_seq_pkg::ST_RS_HI;
      i2c_seq_pkg::ST_RS_HI: begin
        if (!sda_in) st_d = i2c_seq_pkg::ST_RS_SDA;             // not a collision
        else if (tout) st_d = i2c_seq_pkg::ST_RS_SDA;
      end
      i2c_seq_pkg::ST_RS_SDA: if (tout) st_d = i2c_seq_pkg::ST_IDLE; // scl low regardless
      i2c_seq_pkg::ST_TX_LO: if (tout) st_d = i2c_seq_pkg::ST_TX_WAIT;
      i2c_seq_pkg::ST_TX_WAIT: if (scl_in) st_d = i2c_seq_pkg::ST_TX_HI;
      i2c_seq_pkg::ST_TX_HI: begin
        if (tout) st_d = (bit_q == i2c_seq_pkg::BIT_LAST) ? i2c_seq_pkg::ST_IDLE
                                                         : i2c_seq_pkg::ST_TX_LO;
      end
      i2c_seq_pkg::ST_AK_LO: if (tout) st_d = i2c_seq_pkg::ST_AK_WAIT;
      i2c_seq_pkg::ST_AK_WAIT: if (scl_in) st_d = i2c_seq_pkg::ST_AK_HI;
      i2c_seq_pkg::ST_AK_HI: if (tout) st_d = i2c_seq_pkg::ST_IDLE;
      i2c_seq_pkg::ST_SP_LO: if (!sda_in) st_d = i2c_seq_pkg::ST_SP_CNT;
      i2c_seq_pkg::ST_SP_CNT: if (tout) st_d = i2c_seq_pkg::ST_SP_SCL;
      i2c_seq_pkg::ST_SP_SCL: if (tout) st_d = i2c_seq_pkg::ST_SP_DET;
      i2c_seq_pkg::ST_SP_DET: if (stop_ev) st_d = i2c_seq_pkg::ST_SP_END;
      i2c_seq_pkg::ST_SP_END: if (tout) st_d = i2c_seq_pkg::ST_IDLE;
      default: st_d = i2c_seq_pkg::ST_IDLE;
    endcase
    if (!module_enable || bcol_ev) st_d = i2c_seq_pkg::ST_IDLE;
  end

  // generator reloads on every state change and in idle, counts down otherwise and holds at zero
  wire reload_now = (st_d != st_q) || (st_q == i2c_seq_pkg::ST_ST_HI && !sda_in);
  wire [DIV_W-1:0] cnt_d = (reload_now || in_idle) ? reload
                         : (tout ? cnt_q : cnt_q - DIV_W'(i2c_seq_pkg::CNT_ONE));

  // line drive levels per state; only low or released
  // levels follow st_d, so a pin moves on the same edge as the state that owns it
  logic sda_drv_d, scl_drv_d;
  always_comb begin
    sda_drv_d = 1'b0;
    scl_drv_d = 1'b0;
    case (st_d)
      i2c_seq_pkg::ST_ST_SDA:  sda_drv_d = 1'b1;
      i2c_seq_pkg::ST_RS_SCLL: scl_drv_d = 1'b1;
      i2c_seq_pkg::ST_RS_SDA:  sda_drv_d = 1'b1;
      i2c_seq_pkg::ST_TX_LO: begin
        scl_drv_d = 1'b1;
        sda_drv_d = !cur_bit;
      end
      i2c_seq_pkg::ST_TX_WAIT, i2c_seq_pkg::ST_TX_HI: sda_drv_d = !cur_bit;
      i2c_seq_pkg::ST_AK_LO: begin
        scl_drv_d = 1'b1;
        sda_drv_d = !ack_data_value;
      end
      i2c_seq_pkg::ST_AK_WAIT, i2c_seq_pkg::ST_AK_HI: sda_drv_d = !ack_data_value;
      i2c_seq_pkg::ST_SP_LO, i2c_seq_pkg::ST_SP_CNT: begin
        sda_drv_d = 1'b1;
        scl_drv_d = 1'b1;
      end
      i2c_seq_pkg::ST_SP_SCL: sda_drv_d = 1'b1;                   // scl released
      default: begin
        sda_drv_d = 1'b0;
        scl_drv_d = 1'b0;
      end
    endcase
    // scl stays low after a completed start, rstart, ack or byte
    if (st_d == i2c_seq_pkg::ST_IDLE && !bcol_ev && module_enable &&
        (st_q == i2c_seq_pkg::ST_ST_SDA || st_q == i2c_seq_pkg::ST_RS_SDA ||
         st_q == i2c_seq_pkg::ST_AK_HI || st_q == i2c_seq_pkg::ST_TX_HI))
      scl_drv_d = 1'b1;
    if (st_d == i2c_seq_pkg::ST_IDLE && scl_drv_q && st_q == i2c_seq_pkg::ST_IDLE
        && module_enable && !bcol_ev)
      scl_drv_d = 1'b1;                                           // host holds clock between bytes
    if (st_q == i2c_seq_pkg::ST_ST_SDA || st_q == i2c_seq_pkg::ST_RS_SDA)
      sda_drv_d = sda_drv_d || (st_d == i2c_seq_pkg::ST_IDLE && !bcol_ev && module_enable);
  end

  // sequencer, generator and line registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= i2c_seq_pkg::ST_IDLE;
      cnt_q     <= DIV_W'(i2c_seq_pkg::DIV_RESET);
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      sda_p_q   <= 1'b1;
      scl_p_q   <= 1'b1;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sda_drv_q <= sda_drv_d;
      scl_drv_q <= scl_drv_d;
      sda_p_q   <= sda_in;
      scl_p_q   <= scl_in;
    end
  end

  // shifter restarts from the first bit on every accepted write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shreg_q         <= i2c_seq_pkg::BYTE_ZERO;
      bit_q           <= i2c_seq_pkg::BIT_FIRST;
      transfer_buffer <= i2c_seq_pkg::BYTE_ZERO;
    end else if (wr_ok) begin
      shreg_q         <= buf_wdata;                               // refused writes skip
      bit_q           <= i2c_seq_pkg::BIT_FIRST;
      transfer_buffer <= buf_wdata;
    end else if (st_q == i2c_seq_pkg::ST_TX_HI && tout) begin
      shreg_q <= {shreg_q[6:0], 1'b0};
      bit_q   <= bit_q + 3'h1;
    end
  end

  // enables follow the next state, so a refused request never shows a stray enable
  wire ack_en_d  = st_between(st_d, i2c_seq_pkg::ST_AK_LO, i2c_seq_pkg::ST_AK_HI);
  wire stop_en_d = st_between(st_d, i2c_seq_pkg::ST_SP_LO, i2c_seq_pkg::ST_SP_END);
  wire st_en_d   = st_between(st_d, i2c_seq_pkg::ST_ST_HI, i2c_seq_pkg::ST_ST_SDA);
  wire rs_en_d   = st_between(st_d, i2c_seq_pkg::ST_RS_SCLL, i2c_seq_pkg::ST_RS_SDA);

  // sequence enables clear at completion or collision
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_en_q  <= 1'b0;
      stop_en_q <= 1'b0;
      st_en_q   <= 1'b0;
      rs_en_q   <= 1'b0;
    end else begin
      ack_en_q  <= ack_en_d;
      stop_en_q <= stop_en_d;
      st_en_q   <= st_en_d;
      rs_en_q   <= rs_en_d;
    end
  end

  // flags; a hardware set wins over a software clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buffer_full_flag     <= 1'b0;
      write_collision_flag <= 1'b0;
      bus_collision_flag   <= 1'b0;
      serial_irq_flag      <= 1'b0;
      start_seen           <= 1'b0;
      stop_seen            <= 1'b0;
      wake_req             <= 1'b0;
    end else if (!module_enable) begin
      buffer_full_flag <= 1'b0;
      start_seen       <= 1'b0;
      stop_seen        <= 1'b0;
      wake_req         <= 1'b0;
    end else begin
      buffer_full_flag     <= wr_ok || (buffer_full_flag && !byte_end && !bcol_ev);
      write_collision_flag <= wr_col || (write_collision_flag && !write_collision_flag_clear);
      bus_collision_flag   <= bcol_ev || (bus_collision_flag && !bcol_clear);
      // completions, and a stop on the bus outside a stop sequence while irq_enable is set, raise the irq flag
      serial_irq_flag      <= (stop_fin || byte_end || (stop_ev && irq_enable && !in_stop)
                               || ((st_q == i2c_seq_pkg::ST_ST_SDA || st_q == i2c_seq_pkg::ST_RS_SDA
                                   || in_ack) && st_d == i2c_seq_pkg::ST_IDLE && !bcol_ev))
                              || (serial_irq_flag && !irq_clear);
      start_seen           <= start_ev || (start_seen && !stop_ev);
      stop_seen            <= stop_ev || (stop_seen && !start_ev);
      // module keeps working in sleep and wakes the core on byte end
      wake_req             <= sleep_mode && irq_enable && (byte_end || stop_ev || wake_req);
    end
  end

  // open-drain pins: output data always 0
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_oe  <= sda_drv_d;                                       // released on collision
      scl_oe  <= scl_drv_d;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  assign ack_seq_enable    = ack_en_q;
  assign stop_seq_enable   = stop_en_q;
  assign start_seq_enable  = st_en_q;
  assign rstart_seq_enable = rs_en_q;
endmodule

// ===== i2c_far_side.sv
`timescale 1ns/100ps
// far side of the bus: pull-ups, a second host that can pull either line, a slow client
module i2c_far_side (
  input  wire logic       core_clk,
  input  wire logic       sda_oe,
  input  wire logic       scl_oe,
  input  wire logic       peer_sda_low,
  input  wire logic       peer_scl_low,
  input  wire logic [3:0] stretch_len,
  output logic            sda_line,
  output logic            scl_line
);
  logic [3:0] hold_q = 4'h0;
  // client stretches scl after the host lets go, so the host must wait for scl high
  always_ff @(posedge core_clk) begin
    if (scl_oe) hold_q <= stretch_len;
    else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
  end
  // wired-and: a released line floats high through its pull-up
  assign sda_line = !(sda_oe || peer_sda_low);
  assign scl_line = !(scl_oe || peer_scl_low || hold_q != 4'h0);
endmodule

// ===== i2c_host_seq_sva.sv
`timescale 1ns/100ps
module i2c_host_seq_chk (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       module_enable,
  input wire logic       ack_data_value,
  input wire logic       buf_write,
  input wire logic       sda_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       ack_seq_enable,
  input wire logic       stop_seq_enable,
  input wire logic       start_seq_enable,
  input wire logic       rstart_seq_enable,
  input wire logic [7:0] transfer_buffer,
  input wire logic       buffer_full_flag,
  input wire logic       write_collision_flag,
  input wire logic       bus_collision_flag,
  input wire logic       serial_irq_flag,
  input wire logic       start_seen,
  input wire logic       stop_seen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // pins only ever pull low; driving high would fight other hosts
  open_drain_a: assert property (!sda_out && !scl_out)
    else $error("pin driven high");
  ack_drive_a: assert property ($rose(ack_seq_enable) |-> scl_oe && (sda_oe == !ack_data_value))
    else $error("ack start drive wrong");
  ack_end_a: assert property ($fell(ack_seq_enable) && !bus_collision_flag |-> scl_oe)
    else $error("ack end left scl free");
  write_collision_flag_set_a: assert property (buf_write && (ack_seq_enable || stop_seq_enable) |=>
    write_collision_flag && $stable(transfer_buffer)) else $error("busy write accepted");
  stop_start_a: assert property ($rose(stop_seq_enable) |-> sda_oe && scl_oe)
    else $error("stop start drive wrong");
  stop_order_a: assert property (stop_seq_enable && $fell(scl_oe) && !bus_collision_flag |-> sda_oe)
    else $error("sda freed before scl");
  stop_seen_a: assert property (stop_seq_enable && !sda_oe && !scl_oe && sda_in && scl_in
    |-> ##[0:4] stop_seen) else $error("stop not seen");
  stop_irq_a: assert property ($fell(stop_seq_enable) && !bus_collision_flag |->
    ##[0:1] (serial_irq_flag && stop_seen)) else $error("stop end without irq");
  disable_clr_a: assert property (!module_enable |=> !start_seen && !stop_seen && !buffer_full_flag)
    else $error("disable left flags set");
  col_release_a: assert property ($rose(bus_collision_flag) |-> ##[0:1] (!sda_oe && !scl_oe
    && !ack_seq_enable && !stop_seq_enable && !start_seq_enable && !rstart_seq_enable))
    else $error("collision did not abort");
  col_halt_a: assert property ($rose(bus_collision_flag) |-> ##[0:1] !buffer_full_flag)
    else $error("collision kept buffer full");
  // main scenarios reached
  cover property ($fell(ack_seq_enable));
  cover property ($fell(stop_seq_enable));
  cover property ($rose(bus_collision_flag));
  cover property ($rose(write_collision_flag));
endmodule
bind i2c_host_seq i2c_host_seq_chk u_chk (.core_clk, .rstn, .module_enable, .ack_data_value,
  .buf_write, .sda_in, .scl_in, .sda_out, .sda_oe, .scl_out, .scl_oe, .ack_seq_enable,
  .stop_seq_enable, .start_seq_enable, .rstart_seq_enable, .transfer_buffer, .buffer_full_flag,
  .write_collision_flag, .bus_collision_flag, .serial_irq_flag, .start_seen, .stop_seen);

// ===== tb_i2c_host_ack_stop_arbitration.sv
`timescale 1ns/100ps
module tb_i2c_host_ack_stop_arbitration;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       module_enable = 1'b0;
  logic       irq_enable = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       ack_data_value = 1'b0;
  logic       peer_sda_low = 1'b0;
  logic       peer_scl_low = 1'b0;
  logic [3:0] stretch_len = 4'h0;
  logic [6:0] baud_divider_reg = 7'h03;
  logic [7:0] buf_wdata = 8'h00;
  logic [7:0] pls = 8'h00;
  logic [7:0] transfer_buffer;
  logic [7:0] got;
  logic [7:0] exp_q[$];
  logic       sda_in, scl_in, sda_out, sda_oe, scl_out, scl_oe, wake_req;
  logic       ack_seq_enable, stop_seq_enable, start_seq_enable, rstart_seq_enable;
  logic       buffer_full_flag, write_collision_flag, bus_collision_flag;
  logic       serial_irq_flag, start_seen, stop_seen;
  int         num_errors = 0;
  int         n_checks = 0;
  // request pulses: start, rstart, ack, stop, write, write_collision_flag clr, bcol clr, irq clr
  i2c_host_seq u_dut (.core_clk, .rstn, .module_enable, .baud_divider_reg, .irq_enable,
    .sleep_mode, .start_req(pls[0]), .rstart_req(pls[1]), .ack_req(pls[2]), .stop_req(pls[3]),
    .ack_data_value, .buf_write(pls[4]), .buf_wdata, .write_collision_flag_clear(pls[5]), .bcol_clear(pls[6]),
    .irq_clear(pls[7]), .sda_in, .scl_in, .sda_out, .sda_oe, .scl_out, .scl_oe,
    .ack_seq_enable, .stop_seq_enable, .start_seq_enable, .rstart_seq_enable, .transfer_buffer,
    .buffer_full_flag, .write_collision_flag, .bus_collision_flag, .serial_irq_flag,
    .start_seen, .stop_seen, .wake_req);
  i2c_far_side u_far (.core_clk, .sda_oe, .scl_oe, .peer_sda_low, .peer_scl_low, .stretch_len,
    .sda_line(sda_in), .scl_line(scl_in));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic pulse(int i);
    @(posedge core_clk) pls[i] <= 1'b1;
    @(posedge core_clk) pls[i] <= 1'b0;
  endtask
  // bounded wait until no sequence is running
  task automatic idle_wait();
    repeat (2) @(negedge core_clk);
    for (int k = 0; k < 3000 && (ack_seq_enable | stop_seq_enable | start_seq_enable
         | rstart_seq_enable); k++) @(negedge core_clk);
  endtask
  task automatic seq(int i);
    pulse(i);
    idle_wait();
  endtask
  // shift in the eight bits seen on scl rising edges, first bit in the top place
  task automatic grab(output logic [7:0] b);
    logic p;
    int   n;
    p = scl_in;
    n = 0;
    for (int k = 0; k < 4000 && n < 8; k++) begin
      @(negedge core_clk);
      if (scl_in && !p) begin
        b = {b[6:0], sda_in};
        n++;
      end
      p = scl_in;
    end
  endtask
  task automatic tx_done();
    for (int k = 0; k < 4000 && (buffer_full_flag || !serial_irq_flag); k++) @(negedge core_clk);
  endtask
  task automatic send(logic [7:0] v);
    pulse(7);
    exp_q.push_back(v);
    buf_wdata <= v;
    pulse(4);
    @(negedge core_clk);
    chk("full", buffer_full_flag, 1);
    grab(got);
    chk("byte", got, exp_q.pop_front());
    tx_done();
  endtask
  initial begin
    void'($urandom(93));
    baud_divider_reg <= 7'($urandom_range(7, 2));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    module_enable <= 1'b1;
    irq_enable <= 1'b1;
    // both seen bits clear: the bus is ours to take
    @(negedge core_clk);
    chk("seen", {start_seen, stop_seen}, 2'b00);
    seq(0);
    chk("bcol", bus_collision_flag, 0);
    seq(1);
    chk("bcol", bus_collision_flag, 0);
    send(8'($urandom_range(255)));
    // ack then nack, the second against a stretching client
    for (int v = 0; v < 2; v++) begin
      pulse(7);
      ack_data_value <= v[0];
      stretch_len <= v[0] ? 4'h6 : 4'h0;
      pulse(2);
      repeat (2) @(negedge core_clk);
      chk("ack_seq_enable", ack_seq_enable, 1);
      chk("ackdrv", sda_oe, !v[0]);
      pulse(5);
      buf_wdata <= ~got;
      pulse(4);
      @(negedge core_clk);
      chk("write_collision_flag", write_collision_flag, 1);
      chk("buf", transfer_buffer, got);
      idle_wait();
      chk("ack_seq_enable", ack_seq_enable, 0);
    end
    pulse(7);
    stretch_len <= 4'h0;
    seq(3);
    chk("stop", stop_seen, 1);
    chk("irq", serial_irq_flag, 1);
    chk("lines", {sda_in, scl_in}, 2'b11);
    // another host holds sda low through a nack
    pulse(7);
    ack_data_value <= 1'b1;
    peer_sda_low <= 1'b1;
    seq(2);
    chk("bcol", bus_collision_flag, 1);
    chk("ack_seq_enable", ack_seq_enable, 0);
    pulse(7);
    peer_sda_low <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk("irq", serial_irq_flag, 1);
    pulse(6);
    // arbitration lost on the first data bit of a byte
    seq(0);
    @(posedge core_clk) buf_wdata <= 8'hff;
    pulse(4);
    for (int k = 0; k < 500 && !scl_in; k++) @(negedge core_clk);
    @(posedge core_clk) peer_sda_low <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk("bcol", bus_collision_flag, 1);
    chk("full", buffer_full_flag, 0);
    chk("scl", scl_in, 1);
    pulse(7);
    peer_sda_low <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk("irq", serial_irq_flag, 1);
    pulse(6);
    // in sleep a finished byte must wake the core
    sleep_mode <= 1'b1;
    send(8'($urandom_range(255)));
    chk("wake", wake_req, 1);
    seq(3);
    // another party pulls scl low during the first start count
    pulse(0);
    peer_scl_low <= 1'b1;
    idle_wait();
    chk("bcol", bus_collision_flag, 1);
    chk("sten", start_seq_enable, 0);
    @(posedge core_clk) peer_scl_low <= 1'b0;
    pulse(6);
    // start requested while another party holds scl low
    @(posedge core_clk) peer_scl_low <= 1'b1;
    pulse(0);
    repeat (4) @(negedge core_clk);
    chk("bcol", bus_collision_flag, 1);
    chk("sten", start_seq_enable, 0);
    @(posedge core_clk) peer_scl_low <= 1'b0;
    sleep_mode <= 1'b1;
    module_enable <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("seen", {start_seen, stop_seen}, 2'b00);
    print_verdict();
  end
  // a hung handshake ends the run well past the expected few hundred cycles
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
